/* core/cmdp_pkg.sv */
// constants, types and register map for the micro/data pipeline control
// assumes one 20 MHz clock and an Avalon-MM slave of 32-bit words
package cmdp_pkg;
  localparam int DATA_W    = 16;
  localparam int UWORD_W   = 32;
  localparam int UADDR_W   = 16;
  localparam int START_W   = 12;
  localparam int MAP_W     = 8;
  localparam int REG_N     = 8;
  localparam int SR_MAX    = 4;
  localparam logic [3:0] SRC_RESULT = 4'h8;
  localparam int STORE_EN  = 3;
  localparam logic [UWORD_W-1:0] UWORD_NOP = 32'h0000_0000;

  typedef enum logic [2:0] {CMDP_ALU_PASS_R, CMDP_ALU_ADD, CMDP_ALU_SUB, CMDP_ALU_AND,
    CMDP_ALU_OR, CMDP_ALU_XOR, CMDP_ALU_INC_R, CMDP_ALU_PASS_S} cmdp_alu_t;
  typedef enum logic [2:0] {CMDP_SH_NONE, CMDP_SH_LEFT, CMDP_SH_RIGHT, CMDP_SH_SWAP,
    CMDP_SH_SWAP_CLR_HI, CMDP_SH_SWAP_CLR_LO} cmdp_shift_t;
  typedef enum logic [3:0] {CMDP_SK_NEVER, CMDP_SK_FLAG, CMDP_SK_SR0, CMDP_SK_SR1,
    CMDP_SK_SR2, CMDP_SK_SR3, CMDP_SK_SR4, CMDP_SK_TZERO, CMDP_SK_TNZERO,
    CMDP_SK_TODD, CMDP_SK_TEVEN, CMDP_SK_NEXT} cmdp_skip_t;
  typedef enum logic [2:0] {CMDP_SP_NONE, CMDP_SP_SET_CC, CMDP_SP_POP, CMDP_SP_INC_SR,
    CMDP_SP_DEC_SR} cmdp_special_t;
  typedef enum logic [1:0] {CMDP_REF_TRANSFER, CMDP_REF_PROG, CMDP_REF_MOVE,
    CMDP_REF_DATA} cmdp_ref_t;

  typedef struct packed {
    logic [3:0]    rsrc;
    logic [3:0]    ssrc;
    cmdp_alu_t     func;
    logic          use_decimal;
    cmdp_shift_t   shift;
    logic [3:0]    store;
    cmdp_skip_t    skip;
    cmdp_special_t special;
    logic [5:0]    spare;
  } cmdp_uword_t;

  typedef struct packed {
    logic [START_W-1:0] start;
    logic [2:0]         stack_preadjust;
    logic               zero_bit;
    logic               preadder_ctl_bit0;
    logic               preadder_ctl_bit1;
    logic               word_bit;
    logic               jump_via_table_bit;
  } cmdp_lut_t;

  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_NEXT_INSTR = 8'h08;
  localparam logic [7:0] OFS_CUR_INSTR  = 8'h0C;
  localparam logic [7:0] OFS_UADDR      = 8'h10;
  localparam logic [7:0] OFS_CODE_BASE  = 8'h14;
  localparam logic [7:0] OFS_CODE_LIMIT = 8'h18;
  localparam logic [7:0] OFS_DATA_LIMIT = 8'h1C;
  localparam logic [7:0] OFS_DATA_BASE  = 8'h20;
  localparam logic [7:0] OFS_STACK_LIM  = 8'h24;
  localparam logic [7:0] OFS_MEM_SP     = 8'h28;
  localparam logic [7:0] OFS_STACK_PTR  = 8'h2C;
  localparam logic [7:0] OFS_EFF_ADDR   = 8'h30;
  localparam logic [7:0] OFS_STORE_ADDR = 8'h34;
  localparam logic [7:0] OFS_STORE_DATA = 8'h38;
  localparam logic [7:0] OFS_LUT_ADDR   = 8'h3C;
  localparam logic [7:0] OFS_LUT_DATA   = 8'h40;
  localparam logic [7:0] OFS_REG_SEL    = 8'h44;
  localparam logic [7:0] OFS_REG_DATA   = 8'h48;
  localparam logic [7:0] OFS_SR_COUNT   = 8'h4C;
endpackage

/* core/cmdp_core.sv */
// microcode and data pipeline control with its bounds checker
// assumes an Avalon-MM master on sys_clk and sync reset sys_rst
`timescale 1ns/1ps
module cmdp_core
#(
  parameter int STORE_AW = 8
)
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             bounds_violation,
  output logic             stack_overflow,
  output logic             stack_underflow,
  output logic [15:0]      byte_selector,
  output logic [15:0]      preadder_out,
  output logic [15:0]      stack_preadjust_sum
);
  localparam int DW = cmdp_pkg::DATA_W;

  // ****************************************************
  // register bus
  // ****************************************************
  logic        ack_q;
  logic        wr_ok;
  logic [31:0] wdata;
  logic        run_q;
  logic        user_q;
  cmdp_pkg::cmdp_ref_t ref_kind_q;
  logic [DW-1:0] nir_q, cir_q, code_base_q, code_limit_q, data_limit_q, data_base_q;
  logic [DW-1:0] stack_lim_q, mem_sp_q, stack_ptr_q, eff_addr_q;
  logic [STORE_AW-1:0] store_addr_q;
  logic [cmdp_pkg::MAP_W-1:0] lut_addr_q;
  logic [2:0]    reg_sel_q;
  logic          nir_valid_q;
  logic          filled_q;
  logic [2:0]    sr_count_q;
  logic [1:0]    cc_q;
  logic [cmdp_pkg::UADDR_W-1:0] microaddr_reg;
  logic [DW-1:0] regs_q [cmdp_pkg::REG_N];
  logic [cmdp_pkg::UWORD_W-1:0] ustore [2**STORE_AW];
  cmdp_pkg::cmdp_lut_t lookup_table [2**cmdp_pkg::MAP_W];

  assign avs_waitrequest = ~ack_q;
  assign wr_ok = avs_write & ack_q;
  assign wdata = avs_writedata & {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_q)
    begin
      case (avs_address)
        cmdp_pkg::OFS_CTRL:       avs_readdata <= {28'h0000000, ref_kind_q, user_q, run_q};
        cmdp_pkg::OFS_STATUS:     avs_readdata <= {25'h0000000, cc_q, stack_underflow,
                                    stack_overflow, bounds_violation, nir_valid_q, filled_q};
        cmdp_pkg::OFS_NEXT_INSTR: avs_readdata <= {16'h0000, nir_q};
        cmdp_pkg::OFS_CUR_INSTR:  avs_readdata <= {16'h0000, cir_q};
        cmdp_pkg::OFS_UADDR:      avs_readdata <= {16'h0000, microaddr_reg};
        cmdp_pkg::OFS_CODE_BASE:  avs_readdata <= {16'h0000, code_base_q};
        cmdp_pkg::OFS_CODE_LIMIT: avs_readdata <= {16'h0000, code_limit_q};
        cmdp_pkg::OFS_DATA_LIMIT: avs_readdata <= {16'h0000, data_limit_q};
        cmdp_pkg::OFS_DATA_BASE:  avs_readdata <= {16'h0000, data_base_q};
        cmdp_pkg::OFS_STACK_LIM:  avs_readdata <= {16'h0000, stack_lim_q};
        cmdp_pkg::OFS_MEM_SP:     avs_readdata <= {16'h0000, mem_sp_q};
        cmdp_pkg::OFS_STACK_PTR:  avs_readdata <= {16'h0000, stack_ptr_q};
        cmdp_pkg::OFS_EFF_ADDR:   avs_readdata <= {16'h0000, eff_addr_q};
        cmdp_pkg::OFS_REG_DATA:   avs_readdata <= {16'h0000, regs_q[reg_sel_q]};
        cmdp_pkg::OFS_SR_COUNT:   avs_readdata <= {29'h0000000, sr_count_q};
        default:                  avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      run_q        <= 1'b0;
      user_q       <= 1'b0;
      ref_kind_q   <= cmdp_pkg::CMDP_REF_TRANSFER;
      code_base_q  <= 16'h0000;
      code_limit_q <= 16'hFFFF;
      data_limit_q <= 16'h0000;
      data_base_q  <= 16'h0000;
      stack_lim_q  <= 16'hFFFF;
      mem_sp_q     <= 16'h0000;
      stack_ptr_q  <= 16'h0000;
      eff_addr_q   <= 16'h0000;
      store_addr_q <= '0;
      lut_addr_q   <= 8'h00;
      reg_sel_q    <= 3'h0;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        cmdp_pkg::OFS_CTRL:
        begin
          run_q      <= wdata[0];
          user_q     <= wdata[1];
          ref_kind_q <= cmdp_pkg::cmdp_ref_t'(wdata[3:2]);
        end
        cmdp_pkg::OFS_CODE_BASE:  code_base_q  <= wdata[15:0];
        cmdp_pkg::OFS_CODE_LIMIT: code_limit_q <= wdata[15:0];
        cmdp_pkg::OFS_DATA_LIMIT: data_limit_q <= wdata[15:0];
        cmdp_pkg::OFS_DATA_BASE:  data_base_q  <= wdata[15:0];
        cmdp_pkg::OFS_STACK_LIM:  stack_lim_q  <= wdata[15:0];
        cmdp_pkg::OFS_MEM_SP:     mem_sp_q     <= wdata[15:0];
        cmdp_pkg::OFS_STACK_PTR:  stack_ptr_q  <= wdata[15:0];
        cmdp_pkg::OFS_EFF_ADDR:   eff_addr_q   <= wdata[15:0];
        cmdp_pkg::OFS_STORE_ADDR: store_addr_q <= wdata[STORE_AW-1:0];
        cmdp_pkg::OFS_LUT_ADDR:   lut_addr_q   <= wdata[7:0];
        cmdp_pkg::OFS_REG_SEL:    reg_sel_q    <= wdata[2:0];
        default:                  ;
      endcase
    end
  end

  // store and table are software loaded, no reset
  always_ff @(posedge sys_clk)
  begin
    if (wr_ok && avs_address == cmdp_pkg::OFS_STORE_DATA)
      ustore[store_addr_q] <= wdata;
    if (wr_ok && avs_address == cmdp_pkg::OFS_LUT_DATA)
      lookup_table[lut_addr_q] <= cmdp_pkg::cmdp_lut_t'(wdata[19:0]);
  end

  // ****************************************************
  // instruction fetch and mapping
  // ****************************************************
  cmdp_pkg::cmdp_uword_t microword_rank_one, microword_rank_two;
  logic          nir_write;
  logic          take_next;
  logic          pend_q;
  logic          dispatch;
  logic          skip_now;
  logic          jvt_q;
  logic          w_bit_q;
  logic [DW-1:0] instr_selector;
  logic [9:0]    mapper_in;
  logic [7:0]    mapper_ctl;
  logic [7:0]    map_idx;
  cmdp_pkg::cmdp_lut_t lut_out;
  logic [cmdp_pkg::UADDR_W-1:0] microaddr_mux;

  assign nir_write = wr_ok && avs_address == cmdp_pkg::OFS_NEXT_INSTR;
  assign take_next = run_q & nir_valid_q & (~filled_q |
                     (microword_rank_two.skip == cmdp_pkg::CMDP_SK_NEXT && !skip_now));
  // unfilled: nir goes to selector directly; filled: dispatch from cir a cycle later
  assign dispatch = (take_next & ~filled_q) | pend_q;
  assign instr_selector = (filled_q | jvt_q) ? cir_q : nir_q;
  assign mapper_in  = instr_selector[15:6];
  assign mapper_ctl = {w_bit_q, instr_selector[6:0]};
  assign map_idx    = mapper_in[9:2] ^ mapper_ctl;
  assign lut_out    = lookup_table[map_idx];
  assign microaddr_mux = dispatch ?
    {{(cmdp_pkg::UADDR_W-cmdp_pkg::START_W){1'b0}}, lut_out.start} : microaddr_reg;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      nir_q       <= 16'h0000;
      nir_valid_q <= 1'b0;
      cir_q       <= 16'h0000;
      filled_q    <= 1'b0;
      pend_q      <= 1'b0;
    end
    else
    begin
      if (nir_write)
        nir_q <= wdata[15:0];
      nir_valid_q <= nir_write | (nir_valid_q & ~take_next);
      if (take_next)
        cir_q <= nir_q;
      pend_q   <= take_next & filled_q;
      filled_q <= run_q & (filled_q | take_next);
    end
  end

  // special bits routed when an instruction is dispatched
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      jvt_q               <= 1'b0;
      w_bit_q             <= 1'b0;
      byte_selector       <= 16'h0000;
      preadder_out        <= 16'h0000;
      stack_preadjust_sum <= 16'h0000;
    end
    else if (dispatch)
    begin
      jvt_q   <= lut_out.jump_via_table_bit;
      w_bit_q <= lut_out.word_bit;
      byte_selector <= lut_out.jump_via_table_bit ? {8'h00, instr_selector[7:0]} :
                                                    {8'h00, instr_selector[15:8]};
      stack_preadjust_sum <= {13'h0000, sr_count_q} + {13'h0000, lut_out.stack_preadjust};
      if (lut_out.zero_bit)
        preadder_out <= 16'h0000;
      else if (lut_out.preadder_ctl_bit1)
        preadder_out <= {12'h000, instr_selector[3:0]};
      else if (lut_out.word_bit ^ lut_out.preadder_ctl_bit0)
        preadder_out <= {8'h00, instr_selector[7:0]};
      else
        preadder_out <= 16'h0000 - {8'h00, instr_selector[7:0]};
    end
  end

  // ****************************************************
  // microword ranks
  // ****************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      microword_rank_one <= cmdp_pkg::cmdp_uword_t'(cmdp_pkg::UWORD_NOP);
      microword_rank_two <= cmdp_pkg::cmdp_uword_t'(cmdp_pkg::UWORD_NOP);
      microaddr_reg      <= 16'h0000;
    end
    else
    begin
      if (run_q)
        microword_rank_one <= ustore[microaddr_mux[STORE_AW-1:0]];
      else
        microword_rank_one <= cmdp_pkg::cmdp_uword_t'(cmdp_pkg::UWORD_NOP);
      if (skip_now)
        microword_rank_two <= cmdp_pkg::cmdp_uword_t'(cmdp_pkg::UWORD_NOP);
      else
        microword_rank_two <= microword_rank_one;
      microaddr_reg <= microaddr_mux + 16'h0001;
    end
  end

  // ****************************************************
  // data pipeline
  // ****************************************************
  logic [DW-1:0] r_op_q, s_op_q, r_src, s_src, alu_out, shift_out, dec_out, result_bus;

  function automatic logic [DW-1:0] pick_src(input logic [3:0] code,
                                             input logic [DW-1:0] fb);
    logic [DW-1:0] v;
    v = 16'h0000;
    if (code == cmdp_pkg::SRC_RESULT)
      v = fb;
    else if (!code[3])
      v = regs_q[code[2:0]];
    return v;
  endfunction

  function automatic logic [DW-1:0] decimal_fix(input logic [DW-1:0] x);
    logic [DW-1:0] y;
    y = x;
    for (int i = 0; i < DW / 4; i++)
    begin
      if (y[4*i +: 4] > 4'h9)
        y = y + (16'h0006 << (4 * i));
    end
    return y;
  endfunction

  assign r_src = pick_src(microword_rank_one.rsrc, result_bus);
  assign s_src = pick_src(microword_rank_one.ssrc, result_bus);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      r_op_q <= 16'h0000;
      s_op_q <= 16'h0000;
    end
    else
    begin
      r_op_q <= r_src;
      s_op_q <= s_src;
    end
  end

  always_comb
  begin
    case (microword_rank_two.func)
      cmdp_pkg::CMDP_ALU_ADD:   alu_out = r_op_q + s_op_q;
      cmdp_pkg::CMDP_ALU_SUB:   alu_out = r_op_q - s_op_q;
      cmdp_pkg::CMDP_ALU_AND:   alu_out = r_op_q & s_op_q;
      cmdp_pkg::CMDP_ALU_OR:    alu_out = r_op_q | s_op_q;
      cmdp_pkg::CMDP_ALU_XOR:   alu_out = r_op_q ^ s_op_q;
      cmdp_pkg::CMDP_ALU_INC_R: alu_out = r_op_q + 16'h0001;
      cmdp_pkg::CMDP_ALU_PASS_S: alu_out = s_op_q;
      default:                  alu_out = r_op_q;
    endcase
  end

  always_comb
  begin
    case (microword_rank_two.shift)
      cmdp_pkg::CMDP_SH_LEFT:        shift_out = {alu_out[14:0], 1'b0};
      cmdp_pkg::CMDP_SH_RIGHT:       shift_out = {1'b0, alu_out[15:1]};
      cmdp_pkg::CMDP_SH_SWAP:        shift_out = {alu_out[7:0], alu_out[15:8]};
      cmdp_pkg::CMDP_SH_SWAP_CLR_HI: shift_out = {8'h00, alu_out[15:8]};
      cmdp_pkg::CMDP_SH_SWAP_CLR_LO: shift_out = {alu_out[7:0], 8'h00};
      default:                       shift_out = alu_out;
    endcase
  end

  assign dec_out    = decimal_fix(alu_out);
  assign result_bus = microword_rank_two.use_decimal ? dec_out : shift_out;

  // result commits on the edge that retires rank two
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < cmdp_pkg::REG_N; i++)
        regs_q[i] <= 16'h0000;
    end
    else if (microword_rank_two.store[cmdp_pkg::STORE_EN])
      regs_q[microword_rank_two.store[2:0]] <= result_bus;
  end

  // ****************************************************
  // skip and special
  // ****************************************************
  always_comb
  begin
    case (microword_rank_two.skip)
      cmdp_pkg::CMDP_SK_FLAG:   skip_now = cc_q[0];
      cmdp_pkg::CMDP_SK_SR0:    skip_now = sr_count_q == 3'h0;
      cmdp_pkg::CMDP_SK_SR1:    skip_now = sr_count_q == 3'h1;
      cmdp_pkg::CMDP_SK_SR2:    skip_now = sr_count_q == 3'h2;
      cmdp_pkg::CMDP_SK_SR3:    skip_now = sr_count_q == 3'h3;
      cmdp_pkg::CMDP_SK_SR4:    skip_now = sr_count_q == 3'h4;
      cmdp_pkg::CMDP_SK_TZERO:  skip_now = result_bus == 16'h0000;
      cmdp_pkg::CMDP_SK_TNZERO: skip_now = result_bus != 16'h0000;
      cmdp_pkg::CMDP_SK_TODD:   skip_now = result_bus[0];
      cmdp_pkg::CMDP_SK_TEVEN:  skip_now = ~result_bus[0];
      default:                  skip_now = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cc_q       <= 2'b00;
      sr_count_q <= 3'h0;
    end
    else
    begin
      case (microword_rank_two.special)
        cmdp_pkg::CMDP_SP_SET_CC:
          cc_q <= {result_bus[15], result_bus == 16'h0000};
        cmdp_pkg::CMDP_SP_POP,
        cmdp_pkg::CMDP_SP_DEC_SR:
          if (sr_count_q != 3'h0)
            sr_count_q <= sr_count_q - 3'h1;
        cmdp_pkg::CMDP_SP_INC_SR:
          if (sr_count_q != 3'(cmdp_pkg::SR_MAX))
            sr_count_q <= sr_count_q + 3'h1;
        default: ;
      endcase
    end
  end

  // ****************************************************
  // bounds checks
  // ****************************************************
  logic in_code, in_data, check_fail;

  assign in_code = eff_addr_q >= code_base_q && eff_addr_q <= code_limit_q;
  assign in_data = eff_addr_q >= data_limit_q && eff_addr_q <= stack_ptr_q;
  always_comb
  begin
    case (ref_kind_q)
      cmdp_pkg::CMDP_REF_TRANSFER: check_fail = ~in_code;
      cmdp_pkg::CMDP_REF_PROG:     check_fail = user_q & ~in_code;
      cmdp_pkg::CMDP_REF_DATA:     check_fail = user_q & ~in_data;
      default:                     check_fail = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bounds_violation <= 1'b0;
      stack_overflow   <= 1'b0;
      stack_underflow  <= 1'b0;
    end
    else
    begin
      bounds_violation <= check_fail;
      stack_overflow   <= mem_sp_q > stack_lim_q;
      stack_underflow  <= user_q & (mem_sp_q < data_base_q);
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_nop_after_reset: assert property ($fell(sys_rst) |->
    microword_rank_one == cmdp_pkg::UWORD_NOP && microword_rank_two == cmdp_pkg::UWORD_NOP)
    else $error("ranks not nop after reset");
  a_rank_advance: assert property (!skip_now |=>
    microword_rank_two == $past(microword_rank_one))
    else $error("rank two did not take rank one");
  a_skip_nop: assert property (skip_now |=>
    microword_rank_two == cmdp_pkg::UWORD_NOP)
    else $error("skipped word not replaced by nop");
  a_uaddr_step: assert property (!sys_rst |=>
    microaddr_reg == $past(microaddr_mux) + 16'h0001)
    else $error("microaddress not incremented");
  a_store_commit: assert property (microword_rank_two.store[cmdp_pkg::STORE_EN] |=>
    regs_q[$past(microword_rank_two.store[2:0])] == $past(result_bus))
    else $error("result not committed");
  a_operand_latch: assert property (!sys_rst |=>
    r_op_q == $past(r_src) && s_op_q == $past(s_src))
    else $error("operands not latched");
  a_fill_shortcut: assert property (take_next && !filled_q |-> dispatch ##1
    cir_q == $past(nir_q) && filled_q)
    else $error("unfilled pipeline did not dispatch at once");
  a_stack_over: assert property (mem_sp_q > stack_lim_q |=> stack_overflow)
    else $error("overflow not flagged");
  a_user_under: assert property (!user_q |=> !stack_underflow &&
    (!bounds_violation || $past(ref_kind_q) == cmdp_pkg::CMDP_REF_TRANSFER))
    else $error("privileged mode flagged user check");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
endmodule

/* tb/cmdp_mem_model.sv */
// main memory model that hands instruction words to the bench
// assumes the bench asks for a word by index while en is high
`timescale 1ns/1ps
module cmdp_mem_model
(
  input  wire logic        en,
  input  wire logic [3:0]  idx,
  output logic      [15:0] instr
);
  logic [15:0] mem [16];
  logic [15:0] last_q;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'(i * 16'h1357 + 16'h0A5C);
  // released bus shows the inverse of the last word
  always @* if (en) last_q = mem[idx];
  assign instr = en ? mem[idx] : ~last_q;
endmodule

/* tb/cpu_micro_data_pipeline_tb.sv */
// self-checking bench: bounds checks, register access and a short microprogram
// assumes cmdp_core with a one-cycle waitrequest answer
`timescale 1ns/1ps
module cpu_micro_data_pipeline_tb;
  logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, m_en = 0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hF, m_idx = 4'h0;
  logic [15:0] m_instr;
  logic avs_waitrequest, bounds_violation, stack_overflow, stack_underflow;
  int n_mismatch = 0, cmp_count = 0;
  int v[8];
  int usr, knd, f;
  logic [7:0] ofs[8];
  logic [15:0] bsel, padd, psum;
  logic [31:0] pg[16], ev[8];
  cmdp_core #(.STORE_AW(4)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bounds_violation(bounds_violation), .stack_overflow(stack_overflow),
    .stack_underflow(stack_underflow), .byte_selector(bsel), .preadder_out(padd),
    .stack_preadjust_sum(psum));
  cmdp_mem_model u_mem (.en(m_en), .idx(m_idx), .instr(m_instr));
  initial forever #25 sys_clk = ~sys_clk;
  // ************************************************************
  // bus access, comparison and closing
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // microword fields msb first: r, s, func, decimal, shift, store, skip, special
  function automatic logic [31:0] uw(input int r, s, fn, dc, sh, st, sk, sp);
    return {4'(r), 4'(s), 3'(fn), 1'(dc), 3'(sh), 4'(st), 4'(sk), 3'(sp), 6'h00};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    complete_run();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    ofs = '{cmdp_pkg::OFS_CODE_BASE, cmdp_pkg::OFS_CODE_LIMIT, cmdp_pkg::OFS_DATA_LIMIT,
      cmdp_pkg::OFS_DATA_BASE, cmdp_pkg::OFS_STACK_LIM, cmdp_pkg::OFS_MEM_SP,
      cmdp_pkg::OFS_STACK_PTR, cmdp_pkg::OFS_EFF_ADDR};
    void'($urandom(64));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(0, cmdp_pkg::OFS_CODE_LIMIT, 0); chk("code_limit", 32'h0000FFFF, q);
    bus(0, cmdp_pkg::OFS_STACK_LIM, 0); chk("stack_limit", 32'h0000FFFF, q);
    bus(0, cmdp_pkg::OFS_STATUS, 0); chk("status", 32'h0, q);
    bus(0, 8'h7C, 0); chk("unmapped", 32'h0, q);
    for (int k = 0; k < 4; k++)
    begin
      m_idx <= 4'(k);
      m_en <= 1'b1;
      @(posedge sys_clk);
      bus(1, cmdp_pkg::OFS_NEXT_INSTR, {16'h0, m_instr});
      m_en <= 1'b0;
      bus(0, cmdp_pkg::OFS_NEXT_INSTR, 0); chk("next_instr", {16'h0, u_mem.mem[k]}, q);
      bus(0, cmdp_pkg::OFS_STATUS, 0); chk("instr_valid", 32'h2, q & 32'h2);
    end
    for (int t = 0; t < 40; t++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        v[i] = $urandom & 16'hFFFF;
        bus(1, ofs[i], 32'(v[i]));
      end
      usr = $urandom & 1;
      knd = $urandom & 3;
      bus(1, cmdp_pkg::OFS_CTRL, 32'(knd * 4 + usr * 2));
      repeat (2) @(posedge sys_clk);
      f = (knd < 2) ? (v[7] < v[0] || v[7] > v[1]) : (knd == 3) ? (v[7] < v[2] || v[7] > v[6]) : 0;
      f = f && (knd == 0 || usr);
      chk("violation", 32'(f), 32'(bounds_violation));
      chk("overflow", 32'(v[5] > v[4]), 32'(stack_overflow));
      chk("underflow", 32'(usr && v[5] < v[3]), 32'(stack_underflow));
      bus(0, cmdp_pkg::OFS_STATUS, 0);
      chk("status_chk", 32'({usr && v[5] < v[3], v[5] > v[4], f != 0}), 32'(q[4:2]));
    end
    // program: reg1=(r0+1)<<1, reg2=(fb+1)<<1, reg3=dec(r2+r2), sr up, skip over reg5
    pg = '{default: 32'h0000_0000};
    pg[2] = uw(0, 0, 6, 0, 1, 9, 0, 0);
    pg[3] = uw(8, 0, 6, 0, 1, 10, 0, 0);
    pg[5] = uw(2, 2, 1, 1, 0, 11, 0, 0);
    pg[6] = uw(0, 0, 0, 0, 0, 0, 0, 3);
    pg[7] = uw(0, 0, 0, 0, 0, 0, 7, 0);
    pg[8] = uw(0, 0, 6, 0, 0, 13, 0, 0);
    ev = '{32'h0, 32'h2, 32'h6, 32'h12, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int a = 0; a < 16; a++)
    begin
      bus(1, cmdp_pkg::OFS_STORE_ADDR, 32'(a));
      bus(1, cmdp_pkg::OFS_STORE_DATA, pg[a]);
    end
    // every table entry: start 2, preadjust 2, preadder takes low nibble
    for (int a = 0; a < 256; a++)
    begin
      bus(1, cmdp_pkg::OFS_LUT_ADDR, 32'(a));
      bus(1, cmdp_pkg::OFS_LUT_DATA, 32'h0000_0244);
    end
    bus(1, cmdp_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (100) @(posedge sys_clk);
    for (int r = 1; r < 6; r++)
    begin
      bus(1, cmdp_pkg::OFS_REG_SEL, 32'(r));
      bus(0, cmdp_pkg::OFS_REG_DATA, 0);
      chk("reg_data", ev[r], q);
    end
    bus(0, cmdp_pkg::OFS_SR_COUNT, 0); chk("sr_count", 32'(cmdp_pkg::SR_MAX), q);
    bus(0, cmdp_pkg::OFS_CUR_INSTR, 0); chk("cur_instr", {16'h0, u_mem.mem[3]}, q);
    bus(0, cmdp_pkg::OFS_STATUS, 0); chk("filled", 32'h1, q & 32'h3);
    chk("byte_sel", {24'h0, u_mem.mem[3][15:8]}, {16'h0, bsel});
    chk("preadder", {28'h0, u_mem.mem[3][3:0]}, {16'h0, padd});
    chk("preadjust", 32'h2, {16'h0, psum});
    complete_run();
  end
endmodule
